// File: pkg/wfpd_pkg.sv
// Notes on behaviour
// R01 - enable bit enters detection mode, suspends normal reception, checks frames.
// R02 - detection signals host via interrupt or power event, chosen by config.
// R03 - detection sets the wake-frame-received status flag.
// R04 - clearing enable leaves detection and resumes normal reception.
// R05 - software programs all filter words before enabling detection.
// R06 - four independent filters, each with own byte mask and offset.
// R07 - frames addressed to us checked; wake needs address check and CRC match.
// R08 - software sets each offset above 12, beyond the address bytes.
// R09 - mask bit j set includes frame byte offset plus j in CRC.
// R10 - mask is bits 30:0 over 31 bytes; bit 31 written zero.
// R11 - filter port loaded by eight successive writes spread over config words.
// R12 - word order: masks 0-3, command, offsets, CRC 0/1, CRC 2/3.
// R13 - detection works in D0 and D1; in D0 only while enabled.
// R14 - entering D1 forces detection on; software cannot disable it.
// R15 - enabled detection wakes on broadcast despite broadcast-disable.
// R16 - command bit 3 selects multicast when set, unicast when clear.
// R17 - command bit 0 enables filter; bits 2:1 reserved.
// R18 - offset is 8-bit field counted from first destination byte.
// R19 - each filter holds 16-bit reference CRC; equality means wake frame.
// R20 - filter port word pointer advances per write, wraps after eight.
// R21 - CRC-16 computed per byte; all filters judged in parallel at frame end.
package wfpd_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FPORT = 8'h04;
	localparam logic [7:0] ADDR_PTR = 8'h08;
	// ------------------------------------------------------------
	// control/status field positions
	// ------------------------------------------------------------
	localparam int CTRL_WAKE_EN = 0;
	localparam int CTRL_PME_SEL = 1;
	localparam int CTRL_IRQ_SEL = 2;
	localparam int CTRL_BROADCAST_DISABLE_DIS = 3;
	localparam int CTRL_D1 = 4;
	localparam int STAT_RECEIVED = 8;
	localparam int STAT_ACTIVE = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ------------------------------------------------------------
	// filter port layout
	// ------------------------------------------------------------
	localparam int NUM_FILTERS = 4;
	localparam int NUM_WORDS = 8;
	localparam int MASK_BITS = 31;
	localparam logic [2:0] WORD_CMD = 3'h4;
	localparam logic [2:0] WORD_OFS = 3'h5;
	localparam logic [2:0] WORD_CRC01 = 3'h6;
	localparam logic [2:0] WORD_CRC23 = 3'h7;
	localparam int CMD_ENABLE = 0;
	localparam int CMD_MCAST = 3;
	localparam int CMD_STRIDE = 8;
	localparam int OFS_STRIDE = 8;
	localparam int CRC_STRIDE = 16;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	typedef enum logic [1:0] {WF_IDLE, WF_FRAME, WF_JUDGE} wfpd_state_t;
endpackage

// File: logic/wfpd_crc_filter.sv
`timescale 1ns/1ps
module wfpd_crc_filter (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// filter settings
	input wire logic [30:0] byteMask,
	input wire logic [7:0] patOffset,
	input wire logic [15:0] refCrc,
	// frame stream
	input wire logic frameStart,
	input wire logic byteValid,
	input wire logic [10:0] bytePos,
	input wire logic [7:0] byteData,
	// result
	output logic crcMatch
);
	logic [15:0] crc_q;
	logic [11:0] rel;
	logic inWin;
	logic [15:0] nxt;

	assign rel = {1'b0, bytePos} - {4'h0, patOffset};
	assign inWin = ({1'b0, bytePos} >= {4'h0, patOffset}) &&
		(rel < 12'd31) && byteMask[rel[4:0]]; // R09

	always_comb begin
		nxt = crc_q;
		for (int i = 0; i < 8; i++) begin
			if (nxt[15] ^ byteData[i])
				nxt = {nxt[14:0], 1'b0} ^ wfpd_pkg::CRC_POLY;
			else
				nxt = {nxt[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || frameStart)
			crc_q <= wfpd_pkg::CRC_INIT;
		else if (byteValid && inWin)
			crc_q <= nxt; // R21
	end

	assign crcMatch = (crc_q == refCrc); // R19
endmodule

// File: logic/wfpd_filter_port.sv
`timescale 1ns/1ps
module wfpd_filter_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write and read side
	input wire logic wrEn,
	input wire logic [31:0] wrData,
	input wire logic rdEn,
	// stored words
	output logic [31:0] words [8],
	output logic [2:0] ptr,
	output logic [31:0] rdData
);
	logic [2:0] ptr_q;

	always_ff @(posedge clk) begin
		if (!rst_n)
			ptr_q <= 3'h0; // R20
		else if (wrEn || rdEn)
			ptr_q <= ptr_q + 3'h1; // R20
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++)
				words[i] <= 32'h0000_0000;
		end else if (wrEn) begin
			words[ptr_q] <= wrData; // R11
			if (ptr_q < wfpd_pkg::WORD_CMD)
				words[ptr_q][31] <= 1'b0; // R10
		end
	end

	assign ptr = ptr_q;
	assign rdData = words[ptr_q];
endmodule

// File: logic/wfpd_top.sv
`timescale 1ns/1ps
module wfpd_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// power state
	input wire logic powerD1,
	// receive stream from mac
	input wire logic rxStart,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic rxEnd,
	input wire logic rxAddrOk,
	input wire logic rxMulticast,
	input wire logic rxBroadcast,
	// outputs
	output logic normalRxEn,
	output logic irqOut,
	output logic power_event_out
);
	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic apWr_q, apRd_q;
	logic [7:0] apAddr_q;
	logic [31:0] wake_control_status_q;
	logic wake_frame_received_q;
	logic d1Forced_q;
	logic portWr, portRd;
	logic [31:0] portWords [8];
	logic [2:0] portPtr;
	logic [31:0] portRd_data;
	logic detect;
	logic hit;
	wfpd_pkg::wfpd_state_t state_q;

	// transfer accepted at this edge
	logic busReq;
	assign busReq = hready && hsel && htrans[1];

	always_ff @(posedge clk) begin
		if (!rst_n)
			apWr_q <= 1'b0;
		else if (hready)
			apWr_q <= busReq && hwrite;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			apRd_q <= 1'b0;
		else if (hready)
			apRd_q <= busReq && !hwrite;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			apAddr_q <= 8'h00;
		else if (hready)
			apAddr_q <= haddr;
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic ctrlWr;
	assign ctrlWr = apWr_q && (apAddr_q == wfpd_pkg::ADDR_CTRL);
	assign portWr = apWr_q && (apAddr_q == wfpd_pkg::ADDR_FPORT);
	assign portRd = apRd_q && (apAddr_q == wfpd_pkg::ADDR_FPORT);

	// zero wait states, always okay
	always_ff @(posedge clk) begin
		if (!rst_n)
			hreadyout <= 1'b1;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// ------------------------------------------------------------
	// read data, registered at address phase
	// ------------------------------------------------------------
	logic ptrMove;
	logic [2:0] ptrNext;
	logic [31:0] rdMux;

	// a port access in its data phase moves the pointer at this edge
	assign ptrMove = portWr || portRd;
	assign ptrNext = portPtr + 3'h1;

	always_comb begin
		rdMux = 32'h0000_0000;
		case (haddr)
		wfpd_pkg::ADDR_CTRL: begin
			rdMux = wake_control_status_q;
			rdMux[wfpd_pkg::STAT_RECEIVED] = wake_frame_received_q;
			rdMux[wfpd_pkg::STAT_ACTIVE] = detect;
		end
		wfpd_pkg::ADDR_FPORT:
			rdMux = ptrMove ? portWords[ptrNext] : portRd_data;
		wfpd_pkg::ADDR_PTR: rdMux = {29'h0, ptrMove ? ptrNext : portPtr};
		default: rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (busReq && !hwrite)
			hrdata <= rdMux;
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n)
			wake_control_status_q <= wfpd_pkg::CTRL_RESET;
		else if (ctrlWr)
			wake_control_status_q <= {27'h0, hwdata[4:0]}; // R04
	end

	// d1 entry latches detection on until d1 is left
	always_ff @(posedge clk) begin
		if (!rst_n)
			d1Forced_q <= 1'b0;
		else
			d1Forced_q <= powerD1; // R14
	end

	assign detect = wake_control_status_q[wfpd_pkg::CTRL_WAKE_EN] ||
		d1Forced_q; // R13 R14 R01

	// ------------------------------------------------------------
	// filter port
	// ------------------------------------------------------------
	wfpd_filter_port u_port (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(portWr),
		.wrData(hwdata),
		.rdEn(portRd),
		.words(portWords),
		.ptr(portPtr),
		.rdData(portRd_data)
	);

	// ------------------------------------------------------------
	// frame tracking
	// ------------------------------------------------------------
	logic [10:0] pos_q;
	logic frameStart;
	wire [3:0] crcOk;
	wire [3:0] filtHit;
	logic crcByte;

	assign frameStart = rxStart && detect;
	assign crcByte = rxValid && state_q == wfpd_pkg::WF_FRAME;

	always_ff @(posedge clk) begin
		if (!rst_n || rxStart)
			pos_q <= 11'h000;
		else if (rxValid && pos_q != 11'h7ff)
			pos_q <= pos_q + 11'h001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			state_q <= wfpd_pkg::WF_IDLE;
		else begin
			case (state_q)
			wfpd_pkg::WF_IDLE:
				if (frameStart)
					state_q <= wfpd_pkg::WF_FRAME;
			wfpd_pkg::WF_FRAME:
				if (!detect)
					state_q <= wfpd_pkg::WF_IDLE;
				else if (rxEnd)
					state_q <= wfpd_pkg::WF_JUDGE;
			wfpd_pkg::WF_JUDGE:
				state_q <= wfpd_pkg::WF_IDLE;
			default:
				state_q <= wfpd_pkg::WF_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// four filters
	// ------------------------------------------------------------
	for (genvar f = 0; f < wfpd_pkg::NUM_FILTERS; f++) begin : g_filt
		localparam int CMD_LSB = f * wfpd_pkg::CMD_STRIDE;
		localparam int OFS_LSB = f * wfpd_pkg::OFS_STRIDE;
		localparam int CRC_LSB = (f % 2) * wfpd_pkg::CRC_STRIDE;
		localparam int CRC_WORD = wfpd_pkg::WORD_CRC01 + f / 2;
		logic [7:0] cmd;
		logic [30:0] fMask;
		logic [7:0] fOfs;
		logic [15:0] fCrc;
		logic typeOk;

		assign cmd = portWords[wfpd_pkg::WORD_CMD][CMD_LSB +: 8];
		assign fMask = portWords[f][wfpd_pkg::MASK_BITS-1:0]; // R10
		assign fOfs = portWords[wfpd_pkg::WORD_OFS][OFS_LSB +: 8]; // R18 R12
		assign fCrc = portWords[CRC_WORD][CRC_LSB +: 16]; // R12
		// multicast-only when set, unicast-only when clear
		assign typeOk = cmd[wfpd_pkg::CMD_MCAST] ? rxMulticast :
			!rxMulticast; // R16

		wfpd_crc_filter u_crc ( // R06
			.clk(clk),
			.rst_n(rst_n),
			.byteMask(fMask),
			.patOffset(fOfs),
			.refCrc(fCrc),
			.frameStart(rxStart),
			.byteValid(crcByte),
			.bytePos(pos_q),
			.byteData(rxData),
			.crcMatch(crcOk[f])
		);
		assign filtHit[f] = cmd[wfpd_pkg::CMD_ENABLE] && crcOk[f] && // R17
			typeOk;
	end

	// ------------------------------------------------------------
	// judge
	// ------------------------------------------------------------
	// address check and filter results meet in the judge cycle
	// broadcast passes even with broadcast-disable set
	logic addrPass;
	assign addrPass = rxAddrOk || rxBroadcast; // R15 R07

	assign hit = (state_q == wfpd_pkg::WF_JUDGE) && addrPass &&
		(|filtHit); // R21 R07

	// ------------------------------------------------------------
	// status and signalling
	// ------------------------------------------------------------
	// write one to the received bit clears it
	logic clrRecv;
	assign clrRecv = ctrlWr && hwdata[wfpd_pkg::STAT_RECEIVED];

	always_ff @(posedge clk) begin
		if (!rst_n)
			wake_frame_received_q <= 1'b0;
		else if (hit)
			wake_frame_received_q <= 1'b1; // R03
		else if (clrRecv)
			wake_frame_received_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// host signalling
	// ------------------------------------------------------------
	// flag or same-cycle hit drives each host signal whose select bit is set
	logic wakeEvent;
	assign wakeEvent = wake_frame_received_q || hit;

	always_ff @(posedge clk) begin
		if (!rst_n)
			irqOut <= 1'b0;
		else
			irqOut <= wakeEvent &&
				wake_control_status_q[wfpd_pkg::CTRL_IRQ_SEL]; // R02
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			power_event_out <= 1'b0;
		else
			power_event_out <= wakeEvent &&
				wake_control_status_q[wfpd_pkg::CTRL_PME_SEL]; // R02
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			normalRxEn <= 1'b1;
		else
			normalRxEn <= !detect; // R01 R04
	end
endmodule

// File: test/wfpd_chk.sv
`timescale 1ns/1ps
module wfpd_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// power and receive
	input wire logic powerD1,
	input wire logic rxEnd,
	// outputs
	input wire logic normalRxEn,
	input wire logic irqOut,
	input wire logic power_event_out
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic wrA;
	logic rdA;
	assign wrA = hsel && htrans[1] && hwrite && hready;
	assign rdA = hsel && htrans[1] && !hwrite && hready;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence inD1;
		powerD1 [*3];
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	AST_HREADY: assert property (hreadyout)
		else $error("wait state seen");
	AST_OKAY: assert property (!hresp)
		else $error("error response seen");
	AST_HRDATA: assert property ($changed(hrdata) |-> $past(rdA))
		else $error("read data moved without a read");
	AST_D1: assert property (inD1 |-> !normalRxEn)
		else $error("normal reception in low power state");
	AST_IRQ_RISE: assert property ($rose(irqOut) |->
		$past(rxEnd, 2) || $past(wrA, 3))
		else $error("interrupt without frame or write");
	AST_IRQ_FALL: assert property ($fell(irqOut) |->
		$past(wrA, 2) || $past(wrA, 3))
		else $error("interrupt dropped without write");
	AST_PME_RISE: assert property ($rose(power_event_out) |->
		$past(rxEnd, 2) || $past(wrA, 3))
		else $error("power event without frame or write");
	AST_NORMAL_RISE: assert property ($rose(normalRxEn) |->
		!$past(powerD1, 2) && ($past(wrA, 3) || $past(powerD1, 3)))
		else $error("normal reception resumed wrongly");
endmodule
bind wfpd_top wfpd_chk wfpd_chk_i (.clk, .rst_n, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .powerD1, .rxEnd, .normalRxEn,
	.irqOut, .power_event_out);

// File: test/wfpd_rx_model.sv
`timescale 1ns/1ps
module wfpd_rx_model (
	// clock
	input wire logic clk,
	// receive stream
	output logic rxStart = 1'b0,
	output logic rxValid = 1'b0,
	output logic [7:0] rxData = 8'h00,
	output logic rxEnd = 1'b0,
	output logic rxAddrOk = 1'b0,
	output logic rxMulticast = 1'b0,
	output logic rxBroadcast = 1'b0
);
	localparam int FRAME_LEN = 50;
	function automatic logic [7:0] fb(input logic [7:0] sd, input int i);
		return (sd * 8'h3b) ^ 8'(i * 17);
	endfunction
	// odd seeds pace bytes slowly, idle data never stale except after an odd-seed frame ends
	task automatic send(input logic [7:0] sd, input logic [3:0] f);
		@(posedge clk);
		rxStart <= 1'b1;
		for (int i = 0; i < FRAME_LEN; i++) begin
			@(posedge clk);
			rxStart <= 1'b0;
			rxValid <= 1'b1;
			rxData <= fb(sd, i);
			if (sd[0]) begin
				@(posedge clk);
				rxValid <= 1'b0;
				rxData <= ~rxData;
			end
		end
		@(posedge clk);
		rxValid <= 1'b0;
		rxData <= ~rxData;
		rxEnd <= 1'b1;
		rxAddrOk <= f[1];
		rxMulticast <= f[3];
		rxBroadcast <= f[2];
		@(posedge clk);
		rxEnd <= 1'b0;
		@(posedge clk);
		rxAddrOk <= !f[1];
		rxMulticast <= !f[3];
		rxBroadcast <= !f[2];
	endtask
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic powerD1 = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, normalRxEn, irqOut, power_event_out;
	logic rxStart, rxValid, rxEnd, rxAddrOk, rxMulticast, rxBroadcast;
	logic [7:0] rxData;
	logic [31:0] hrdata, rd;
	logic [31:0] words [8];
	// ctrl, seed, flags: d1 mcast broadcast addrok hit
	logic [23:0] cases [9] = '{24'h05_01_03, 24'h03_02_0b, 24'h07_02_02,
		24'h07_03_02, 24'h07_04_02, 24'h07_01_00, 24'h0f_02_0d,
		24'h06_01_02, 24'h06_01_13};
	int nMismatch = 0;
	int checkCount = 0;
	initial begin
		forever #2.5 clk = ~clk;
	end
	wfpd_top wfpd_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .powerD1(powerD1), .rxStart(rxStart),
		.rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
		.rxAddrOk(rxAddrOk), .rxMulticast(rxMulticast),
		.rxBroadcast(rxBroadcast), .normalRxEn(normalRxEn), .irqOut(irqOut),
		.power_event_out(power_event_out));
	wfpd_rx_model rxm_i (.clk(clk), .rxStart(rxStart), .rxValid(rxValid),
		.rxData(rxData), .rxEnd(rxEnd), .rxAddrOk(rxAddrOk),
		.rxMulticast(rxMulticast), .rxBroadcast(rxBroadcast));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic busOp(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// reference crc over the masked bytes of one filter
	function automatic logic [15:0] crcOf(input int k, input logic [7:0] sd);
		logic [15:0] c;
		logic [7:0] b;
		c = wfpd_pkg::CRC_INIT;
		for (int j = 0; j < 31; j++) begin
			if (words[k][j]) begin
				b = rxm_i.fb(sd, 13 + k + j);
				for (int i = 0; i < 8; i++) begin
					c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? wfpd_pkg::CRC_POLY : 16'h0);
				end
			end
		end
		return c;
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		conclude();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [23:0] c;
		for (int k = 0; k < 4; k++) begin
			words[k] = 32'h4000_0001 | (32'h0000_0055 << k);
		end
		words[4] = 32'h0100_0907;
		words[5] = 32'h100f_0e0d;
		words[6] = {crcOf(1, 8'h02), crcOf(0, 8'h01)};
		words[7] = {crcOf(3, 8'h04) ^ 16'h0001, crcOf(2, 8'h03)};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cmp({31'h0, normalRxEn}, 32'h1);
		busOp(1'b0, 8'h00, 32'h0, rd);
		cmp(rd, 32'h0);
		busOp(1'b0, 8'h08, 32'h0, rd);
		cmp(rd, 32'h0);
		busOp(1'b1, 8'h0c, 32'hffff_ffff, rd);
		busOp(1'b0, 8'h0c, 32'h0, rd);
		cmp(rd, 32'h0);
		for (int k = 0; k < 8; k++) begin
			busOp(1'b1, 8'h04, words[k], rd);
		end
		busOp(1'b0, 8'h08, 32'h0, rd);
		cmp(rd, 32'h0);
		for (int k = 0; k < 8; k++) begin
			busOp(1'b0, 8'h04, 32'h0, rd);
			cmp(rd, words[k]);
		end
		for (int n = 0; n < 9; n++) begin
			c = cases[n];
			powerD1 <= c[4];
			busOp(1'b1, 8'h00, {24'h1, c[23:16]}, rd);
			repeat (3) @(posedge clk);
			cmp({31'h0, normalRxEn}, {31'h0, !(c[16] | c[4])});
			rxm_i.send(c[15:8], c[3:0]);
			repeat (5) @(posedge clk);
			busOp(1'b0, 8'h00, 32'h0, rd);
			cmp(rd, {22'h0, c[16] | c[4], c[0], c[23:16]});
			cmp({30'h0, irqOut, power_event_out},
				{30'h0, c[0] & c[18], c[0] & c[17]});
		end
		powerD1 <= 1'b0;
		conclude();
	end
endmodule
